// [hw/framer_defines.svh]
// Byte values, field positions, counts and register offsets for the framer.
// Assumes inclusion by bare name from hw/; definitions only.
`ifndef FRAMER_DEFINES_SVH
`define FRAMER_DEFINES_SVH

`define FRAME_START_MARKER 8'hFB
`define DIR_CMD            4'h0
`define DIR_REPLY          4'h1
`define DIR_EVENT          4'h2
`define KIND_EVENT_BIT     5
`define KIND_REPLY_BIT     4
`define TYPE_MODE_ENTRY    4'h0
`define TYPE_MODE_EXIT     4'h1
`define MODE_ENTRY_LEN     8'h07
`define MODE_ACK_LEN       8'h01
`define MODE_EXIT_LEN      8'h01
`define MODE_KEY           48'h4746_4354_4E44
`define ARG_BYTES          8'h08

`define REG_CTRL           8'h00
`define REG_TXHDR          8'h04
`define REG_TXARG_LO       8'h08
`define REG_TXARG_HI       8'h0C
`define REG_RXINFO         8'h10
`define REG_RXARG_LO       8'h14
`define REG_RXARG_HI       8'h18
`define REG_STATUS         8'h1C
`define REG_MASK           8'h20
`define REG_RAW            8'h24

`define ST_REPLY           0
`define ST_EVENT           1
`define ST_RAW             2
`define ST_BAD             3
`define ST_TXDONE          4
`define ST_WIDTH           5

`endif

// [hw/framer_pkg.sv]
// Types shared by both ends of the framed serial link.
// Assumes nothing beyond a SystemVerilog compiler.
package framer_pkg;
  typedef enum logic [1:0] {RX_HUNT, RX_LEN, RX_KIND, RX_ARGS} rx_state_t;
  typedef enum logic [1:0] {TX_IDLE, TX_LEN, TX_KIND, TX_ARGS} tx_state_t;
  typedef logic [7:0]  byte_t;
  typedef logic [63:0] args_t;
endpackage

// [hw/host_framer.sv]
// Host end of the framed serial link with an Avalon-MM register slave.
// Assumes the radio end shares the clock and accepts every byte.
module host_framer (
  input  wire logic          i_clock,
  input  wire logic          i_rst_n,
  serial_link_if.host        lnk,
  input  wire logic [7:0]    i_address,
  input  wire logic          i_read,
  input  wire logic          i_write,
  input  wire logic [31:0]   i_writedata,
  input  wire logic [3:0]    i_byteenable,
  output logic [31:0]        o_readdata,
  output logic               o_waitrequest,
  output logic               o_irq
);
  import framer_pkg::*;
`include "framer_defines.svh"

  typedef struct packed {
    rx_state_t            rx_st;
    byte_t                rx_len;
    byte_t                rx_cnt;
    byte_t                rx_kind;
    args_t                rx_args;
    byte_t                got_kind;
    byte_t                got_len;
    args_t                got_args;
    byte_t                raw_last;
    tx_state_t            tx_st;
    byte_t                tx_len;
    byte_t                tx_cnt;
    args_t                tx_args;
    logic [31:0]          hdr;
    args_t                arg_cfg;
    byte_t                out_data;
    logic                 out_valid;
    logic [`ST_WIDTH-1:0] status;
    logic [`ST_WIDTH-1:0] mask;
    logic [31:0]          rdata;
    logic                 bus_done;
  } host_state_t;

  host_state_t          s_ff;
  host_state_t          nxt_s;
  logic                 req;
  logic                 acc;
  logic [31:0]          wmask;
  logic [`ST_WIDTH-1:0] set_bits;
  logic [`ST_WIDTH-1:0] clr_bits;
  logic                 rx_done;
  byte_t                rx_byte;

  assign req = i_read || i_write;
  // One wait cycle: read data is staged, then the access completes
  assign acc = req && s_ff.bus_done;
  assign o_waitrequest = req && !s_ff.bus_done;
  assign rx_byte = lnk.d2h_data;
  assign wmask = {{8{i_byteenable[3]}}, {8{i_byteenable[2]}},
                  {8{i_byteenable[1]}}, {8{i_byteenable[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] m,
                                        input logic [31:0] d);
    merge = (old_v & ~m) | (d & m);
  endfunction

  always_comb begin
    nxt_s = s_ff;
    nxt_s.out_valid = 1'b0;
    set_bits = '0;
    clr_bits = '0;
    rx_done = 1'b0;
    nxt_s.bus_done = req && !s_ff.bus_done;

    case (i_address)
      `REG_TXHDR:    nxt_s.rdata = s_ff.hdr;
      `REG_TXARG_LO: nxt_s.rdata = s_ff.arg_cfg[31:0];
      `REG_TXARG_HI: nxt_s.rdata = s_ff.arg_cfg[63:32];
      `REG_RXINFO:   nxt_s.rdata = {15'h0000, s_ff.tx_st != TX_IDLE,
                                    s_ff.got_len, s_ff.got_kind};
      `REG_RXARG_LO: nxt_s.rdata = s_ff.got_args[31:0];
      `REG_RXARG_HI: nxt_s.rdata = s_ff.got_args[63:32];
      `REG_STATUS:   nxt_s.rdata = {27'h0000000, s_ff.status};
      `REG_MASK:     nxt_s.rdata = {27'h0000000, s_ff.mask};
      `REG_RAW:      nxt_s.rdata = {24'h000000, s_ff.raw_last};
      default:       nxt_s.rdata = 32'h00000000;
    endcase
    // Only bits already shown to software are cleared, so none is lost
    if (acc && i_read && i_address == `REG_STATUS) begin
      clr_bits = s_ff.rdata[`ST_WIDTH-1:0];
    end

    if (acc && i_write) begin
      case (i_address)
        `REG_TXHDR:    nxt_s.hdr = merge(s_ff.hdr, wmask, i_writedata);
        `REG_TXARG_LO: nxt_s.arg_cfg[31:0] =
                         merge(s_ff.arg_cfg[31:0], wmask, i_writedata);
        `REG_TXARG_HI: nxt_s.arg_cfg[63:32] =
                         merge(s_ff.arg_cfg[63:32], wmask, i_writedata);
        `REG_MASK:     nxt_s.mask = i_byteenable[0] ?
                         i_writedata[`ST_WIDTH-1:0] : s_ff.mask;
        default:       nxt_s.hdr = s_ff.hdr;
      endcase
    end

    case (s_ff.tx_st)
      TX_IDLE: begin
        // Send requests while busy are ignored
        if (acc && i_write && i_byteenable[0]) begin
          if (i_address == `REG_CTRL && i_writedata[0]) begin
            nxt_s.out_data = `FRAME_START_MARKER;
            nxt_s.out_valid = 1'b1;
            nxt_s.tx_len = {4'h0, s_ff.hdr[11:8]} + 8'h01;
            nxt_s.tx_args = s_ff.arg_cfg;
            nxt_s.tx_cnt = 8'h00;
            nxt_s.tx_st = TX_LEN;
          end else if (i_address == `REG_RAW) begin
            nxt_s.out_data = i_writedata[7:0];
            nxt_s.out_valid = 1'b1;
          end
        end
      end
      TX_LEN: begin
        nxt_s.out_data = s_ff.tx_len;
        nxt_s.out_valid = 1'b1;
        nxt_s.tx_st = TX_KIND;
      end
      TX_KIND: begin
        nxt_s.out_data = {`DIR_CMD, s_ff.hdr[3:0]};
        nxt_s.out_valid = 1'b1;
        nxt_s.tx_st = (s_ff.tx_len == 8'h01) ? TX_IDLE : TX_ARGS;
        set_bits[`ST_TXDONE] = (s_ff.tx_len == 8'h01);
      end
      TX_ARGS: begin
        nxt_s.out_data = s_ff.tx_args[7:0];
        nxt_s.out_valid = 1'b1;
        nxt_s.tx_args = {8'h00, s_ff.tx_args[63:8]};
        nxt_s.tx_cnt = s_ff.tx_cnt + 8'h01;
        if (s_ff.tx_cnt == s_ff.tx_len - 8'h02) begin
          nxt_s.tx_st = TX_IDLE;
          set_bits[`ST_TXDONE] = 1'b1;
        end
      end
      default: begin
        nxt_s.tx_st = TX_IDLE;
      end
    endcase

    if (lnk.d2h_valid) begin
      case (s_ff.rx_st)
        RX_HUNT: begin
          if (rx_byte == `FRAME_START_MARKER) begin
            nxt_s.rx_st = RX_LEN;
          end else begin
            nxt_s.raw_last = rx_byte;
            set_bits[`ST_RAW] = 1'b1;
          end
        end
        RX_LEN: begin
          if (rx_byte == 8'h00) begin
            set_bits[`ST_BAD] = 1'b1;
            nxt_s.rx_st = RX_HUNT;
          end else begin
            nxt_s.rx_len = rx_byte;
            nxt_s.rx_cnt = 8'h00;
            nxt_s.rx_args = '0;
            nxt_s.rx_st = RX_KIND;
          end
        end
        RX_KIND: begin
          nxt_s.rx_kind = rx_byte;
          rx_done = (s_ff.rx_len == 8'h01);
          nxt_s.rx_st = rx_done ? RX_HUNT : RX_ARGS;
        end
        RX_ARGS: begin
          if (s_ff.rx_cnt < `ARG_BYTES) begin
            nxt_s.rx_args[{s_ff.rx_cnt[2:0], 3'b000} +: 8] = rx_byte;
          end
          nxt_s.rx_cnt = s_ff.rx_cnt + 8'h01;
          if (s_ff.rx_cnt == s_ff.rx_len - 8'h02) begin
            rx_done = 1'b1;
            nxt_s.rx_st = RX_HUNT;
          end
        end
        default: begin
          nxt_s.rx_st = RX_HUNT;
        end
      endcase
    end

    if (rx_done) begin
      nxt_s.got_kind = nxt_s.rx_kind;
      nxt_s.got_len = s_ff.rx_len;
      nxt_s.got_args = nxt_s.rx_args;
      if (nxt_s.rx_kind[`KIND_EVENT_BIT]) begin
        set_bits[`ST_EVENT] = 1'b1;
      end else if (nxt_s.rx_kind[`KIND_REPLY_BIT]) begin
        set_bits[`ST_REPLY] = 1'b1;
      end else begin
        set_bits[`ST_BAD] = 1'b1;
      end
    end
    // Set wins over a clear in the same cycle
    nxt_s.status = (s_ff.status & ~clr_bits) | set_bits;
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign lnk.h2d_data  = s_ff.out_data;
  assign lnk.h2d_valid = s_ff.out_valid;
  assign o_readdata    = s_ff.rdata;
  assign o_irq         = |(s_ff.status & s_ff.mask);
endmodule // host_framer

// [hw/radio_framer.sv]
// Radio end of the framed serial link: parses host commands, frames
// replies and events, and passes raw bytes in transparent mode.
// Assumes the host end runs on the same clock and accepts every byte.
// Function
// - Frames begin with start marker byte
// - Marker, length, kind, then arguments
// - Length counts bytes after the length
// - Kind bits 7..6 reserved, sent clear, ignored
// - Device events set kind bit five
// - Reply copies command type, sets bit four
// - Kind low nibble selects message handling
// - Commands high nibble zero, replies one
// - Device events carry high nibble two
// - Arguments concatenated in fixed order
// - Multibyte arguments sent low byte first
// - Transparent and framed serial modes
// - Most commands get a matching reply
// - Mode entry: length seven, key, ack
module radio_framer (
  input  wire logic                 i_clock,
  input  wire logic                 i_rst_n,
  serial_link_if.dev                lnk,
  output logic                      o_framed,
  output logic                      o_raw_valid,
  output framer_pkg::byte_t         o_raw_data,
  input  wire logic                 i_raw_valid,
  input  wire framer_pkg::byte_t    i_raw_data,
  output logic                      o_raw_ready,
  output logic                      o_cmd_valid,
  output logic [3:0]                o_cmd_type,
  output framer_pkg::byte_t         o_cmd_len,
  output framer_pkg::args_t         o_cmd_args,
  input  wire logic                 i_rsp_valid,
  input  wire logic [3:0]           i_rsp_type,
  input  wire logic [3:0]           i_rsp_cnt,
  input  wire framer_pkg::args_t    i_rsp_args,
  output logic                      o_rsp_ready,
  input  wire logic                 i_evt_valid,
  input  wire logic [3:0]           i_evt_type,
  input  wire logic [3:0]           i_evt_cnt,
  input  wire framer_pkg::args_t    i_evt_args,
  output logic                      o_evt_ready
);
  import framer_pkg::*;
`include "framer_defines.svh"

  typedef struct packed {
    rx_state_t  rx_st;
    byte_t      rx_len;
    byte_t      rx_cnt;
    byte_t      rx_kind;
    args_t      rx_args;
    logic       framed;
    logic       ack_pend;
    tx_state_t  tx_st;
    byte_t      tx_len;
    byte_t      tx_cnt;
    byte_t      tx_kind;
    args_t      tx_args;
    byte_t      out_data;
    logic       out_valid;
    logic       raw_valid;
    byte_t      raw_data;
    logic       cmd_valid;
    logic [3:0] cmd_type;
    byte_t      cmd_len;
    args_t      cmd_args;
  } dev_state_t;

  dev_state_t s_ff;
  dev_state_t nxt_s;
  logic       rx_done;
  logic       tx_free;
  byte_t      rx_byte;

  assign rx_byte = lnk.h2d_data;
  // Replies and events wait while a mode-entry ack is still owed
  assign tx_free = (s_ff.tx_st == TX_IDLE) && !s_ff.ack_pend;
  assign o_rsp_ready = tx_free && s_ff.framed;
  assign o_evt_ready = tx_free && s_ff.framed && !i_rsp_valid;
  assign o_raw_ready = tx_free && !s_ff.framed;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.out_valid = 1'b0;
    nxt_s.raw_valid = 1'b0;
    nxt_s.cmd_valid = 1'b0;
    rx_done = 1'b0;

    case (s_ff.tx_st)
      TX_IDLE: begin
        if (s_ff.ack_pend) begin
          nxt_s.tx_kind = {`DIR_REPLY, `TYPE_MODE_ENTRY};
          nxt_s.tx_len = `MODE_ACK_LEN;
          nxt_s.tx_args = '0;
          nxt_s.ack_pend = 1'b0;
        end else if (s_ff.framed && i_rsp_valid) begin
          nxt_s.tx_kind = {`DIR_REPLY, i_rsp_type};
          nxt_s.tx_len = {4'h0, i_rsp_cnt} + 8'h01;
          nxt_s.tx_args = i_rsp_args;
        end else if (s_ff.framed && i_evt_valid) begin
          nxt_s.tx_kind = {`DIR_EVENT, i_evt_type};
          nxt_s.tx_len = {4'h0, i_evt_cnt} + 8'h01;
          nxt_s.tx_args = i_evt_args;
        end else if (!s_ff.framed && i_raw_valid) begin
          nxt_s.out_data = i_raw_data;
          nxt_s.out_valid = 1'b1;
        end
        if (s_ff.ack_pend || (s_ff.framed && (i_rsp_valid || i_evt_valid))) begin
          nxt_s.out_data = `FRAME_START_MARKER;
          nxt_s.out_valid = 1'b1;
          nxt_s.tx_cnt = 8'h00;
          nxt_s.tx_st = TX_LEN;
        end
      end
      TX_LEN: begin
        nxt_s.out_data = s_ff.tx_len;
        nxt_s.out_valid = 1'b1;
        nxt_s.tx_st = TX_KIND;
      end
      TX_KIND: begin
        nxt_s.out_data = s_ff.tx_kind;
        nxt_s.out_valid = 1'b1;
        nxt_s.tx_st = (s_ff.tx_len == 8'h01) ? TX_IDLE : TX_ARGS;
      end
      TX_ARGS: begin
        nxt_s.out_data = s_ff.tx_args[7:0];
        nxt_s.out_valid = 1'b1;
        nxt_s.tx_args = {8'h00, s_ff.tx_args[63:8]};
        nxt_s.tx_cnt = s_ff.tx_cnt + 8'h01;
        if (s_ff.tx_cnt == s_ff.tx_len - 8'h02) begin
          nxt_s.tx_st = TX_IDLE;
        end
      end
      default: begin
        nxt_s.tx_st = TX_IDLE;
      end
    endcase

    if (lnk.h2d_valid) begin
      case (s_ff.rx_st)
        RX_HUNT: begin
          if (rx_byte == `FRAME_START_MARKER) begin
            nxt_s.rx_st = RX_LEN;
          end else if (!s_ff.framed) begin
            nxt_s.raw_data = rx_byte;
            nxt_s.raw_valid = 1'b1;
          end
        end
        RX_LEN: begin
          if (rx_byte == 8'h00) begin
            nxt_s.rx_st = RX_HUNT;
          end else begin
            nxt_s.rx_len = rx_byte;
            nxt_s.rx_cnt = 8'h00;
            nxt_s.rx_args = '0;
            nxt_s.rx_st = RX_KIND;
          end
        end
        RX_KIND: begin
          nxt_s.rx_kind = rx_byte;
          if (s_ff.rx_len == 8'h01) begin
            rx_done = 1'b1;
            nxt_s.rx_st = RX_HUNT;
          end else begin
            nxt_s.rx_st = RX_ARGS;
          end
        end
        RX_ARGS: begin
          if (s_ff.rx_cnt < `ARG_BYTES) begin
            nxt_s.rx_args[{s_ff.rx_cnt[2:0], 3'b000} +: 8] = rx_byte;
          end
          nxt_s.rx_cnt = s_ff.rx_cnt + 8'h01;
          if (s_ff.rx_cnt == s_ff.rx_len - 8'h02) begin
            rx_done = 1'b1;
            nxt_s.rx_st = RX_HUNT;
          end
        end
        default: begin
          nxt_s.rx_st = RX_HUNT;
        end
      endcase
    end

    if (rx_done) begin
      if (nxt_s.rx_kind[`KIND_EVENT_BIT:`KIND_REPLY_BIT] != 2'b00) begin
        nxt_s.rx_st = RX_HUNT;
      end else if (nxt_s.rx_kind[3:0] == `TYPE_MODE_ENTRY) begin
        if (s_ff.rx_len == `MODE_ENTRY_LEN &&
            nxt_s.rx_args[47:0] == `MODE_KEY) begin
          nxt_s.framed = 1'b1;
          nxt_s.ack_pend = 1'b1;
        end
      end else if (s_ff.framed) begin
        if (nxt_s.rx_kind[3:0] == `TYPE_MODE_EXIT &&
            s_ff.rx_len == `MODE_EXIT_LEN) begin
          nxt_s.framed = 1'b0;
        end else begin
          nxt_s.cmd_valid = 1'b1;
          nxt_s.cmd_type = nxt_s.rx_kind[3:0];
          nxt_s.cmd_len = s_ff.rx_len;
          nxt_s.cmd_args = nxt_s.rx_args;
        end
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign lnk.d2h_data  = s_ff.out_data;
  assign lnk.d2h_valid = s_ff.out_valid;
  assign o_framed      = s_ff.framed;
  assign o_raw_valid   = s_ff.raw_valid;
  assign o_raw_data    = s_ff.raw_data;
  assign o_cmd_valid   = s_ff.cmd_valid;
  assign o_cmd_type    = s_ff.cmd_type;
  assign o_cmd_len     = s_ff.cmd_len;
  assign o_cmd_args    = s_ff.cmd_args;
endmodule // radio_framer

// [hw/serial_link_if.sv]
// Byte-wide serial link between host controller and radio end.
// Both ends share one clock; a valid strobe carries one byte per cycle.
interface serial_link_if;
  logic [7:0] h2d_data;
  logic       h2d_valid;
  logic [7:0] d2h_data;
  logic       d2h_valid;

  modport host (output h2d_data, output h2d_valid,
                input  d2h_data, input  d2h_valid);
  modport dev  (input  h2d_data, input  h2d_valid,
                output d2h_data, output d2h_valid);
endinterface

// [tb/serial_link_chk.sv]
// Wire checks for the framed serial link between host and radio ends.
// Assumes one shared clock; sits beside the link interface instance.
`include "framer_defines.svh"
module frame_track (
  input  wire logic       i_clock,
  input  wire logic       i_rst_n,
  input  wire logic       i_valid,
  input  wire logic [7:0] i_data,
  output logic      [1:0] o_pos,
  output logic      [7:0] o_kind,
  output logic      [7:0] o_len,
  output logic      [7:0] o_rem
);
  timeunit 1ns;
  timeprecision 1ps;
  // Follows the length byte, so a marker inside a frame stays data
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_pos  <= 2'h0;
      o_kind <= 8'h00;
      o_len  <= 8'h00;
      o_rem  <= 8'h00;
    end else if (i_valid) begin
      case (o_pos)
        2'h0: if (i_data == `FRAME_START_MARKER) o_pos <= 2'h1;
        2'h1: begin
          o_len <= i_data;
          o_rem <= i_data;
          o_pos <= (i_data == 8'h00) ? 2'h0 : 2'h2;
        end
        default: begin
          if (o_pos == 2'h2) o_kind <= i_data;
          o_rem <= o_rem - 8'h01;
          o_pos <= (o_rem == 8'h01) ? 2'h0 : 2'h3;
        end
      endcase
    end
  end
endmodule // frame_track

module serial_link_chk (
  input  wire logic       i_clock,
  input  wire logic       i_rst_n,
  input  wire logic [7:0] i_h2d_data,
  input  wire logic       i_h2d_valid,
  input  wire logic [7:0] i_d2h_data,
  input  wire logic       i_d2h_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0]  h_pos, d_pos;
  logic [7:0]  h_kind, h_len, h_rem;
  logic [47:0] key_sr;
  logic        h_last, key_ok;

  frame_track u_h_track (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_valid(i_h2d_valid), .i_data(i_h2d_data), .o_pos(h_pos),
    .o_kind(h_kind), .o_len(h_len), .o_rem(h_rem));
  frame_track u_d_track (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_valid(i_d2h_valid), .i_data(i_d2h_data), .o_pos(d_pos),
    .o_kind(), .o_len(), .o_rem());

  always_ff @(posedge i_clock)
    if (i_h2d_valid) key_sr <= {key_sr[39:0], i_h2d_data};
  assign h_last = i_h2d_valid && h_pos[1] && (h_rem == 8'h01);
  assign key_ok = {key_sr[39:0], i_h2d_data} == 48'h444E54434647;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  chk_quiet_reset: assert property (disable iff (1'b0)
    !i_rst_n |=> !i_h2d_valid && !i_d2h_valid)
    else $error("link strobe high after reset");
  chk_h2d_len: assert property (
    h_pos == 2'h1 |-> i_h2d_valid && i_h2d_data inside {[8'h01:8'h09]})
    else $error("host length byte missing or out of range");
  chk_h2d_contig: assert property (
    h_pos != 2'h0 |-> i_h2d_valid)
    else $error("host frame has a gap");
  chk_h2d_kind: assert property (
    h_pos == 2'h2 |-> i_h2d_data[7:4] == `DIR_CMD)
    else $error("host kind has wrong direction");
  chk_d2h_len: assert property (
    d_pos == 2'h1 |-> i_d2h_valid && i_d2h_data inside {[8'h01:8'h09]})
    else $error("radio length byte missing or out of range");
  chk_d2h_contig: assert property (
    d_pos != 2'h0 |-> i_d2h_valid)
    else $error("radio frame has a gap");
  chk_d2h_kind: assert property (
    d_pos == 2'h2 |-> i_d2h_data[7:6] == 2'b00
      && (i_d2h_data[5:4] == 2'b01 || i_d2h_data[5:4] == 2'b10))
    else $error("radio kind has bad direction bits");
  chk_ack_timing: assert property (
    h_last && key_ok && h_len == `MODE_ENTRY_LEN && h_kind[5:0] == 6'h00
    |-> ##2 (i_d2h_valid && i_d2h_data == `FRAME_START_MARKER)
    ##1 (i_d2h_valid && i_d2h_data == `MODE_ACK_LEN)
    ##1 (i_d2h_valid && i_d2h_data == {`DIR_REPLY, `TYPE_MODE_ENTRY}))
    else $error("mode entry not acknowledged in time");

  cov_entry: cover property (h_last && key_ok);
  cov_event: cover property (d_pos == 2'h2 && i_d2h_valid && i_d2h_data[5]);
  cov_reply: cover property (d_pos == 2'h2 && i_d2h_valid && i_d2h_data[4]);
endmodule // serial_link_chk

// [tb/serial_protocol_message_framer_tb_top.sv]
// Bench: host end and radio end face each other over the link.
// Assumes Avalon-MM on the host side and plain ports on the radio side.
`include "framer_defines.svh"
module serial_protocol_message_framer_tb_top import framer_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clock = 1'b0, i_rst_n = 1'b0;
  logic [7:0]  address = 8'h00;
  logic        read = 1'b0, write = 1'b0;
  logic [31:0] writedata = 32'h0, readdata, rdata_s;
  logic        waitrequest, irq, framed, raw_ov, raw_rdy, cmd_v;
  logic        raw_iv = 1'b0, rsp_v = 1'b0, evt_v = 1'b0;
  logic        rsp_rdy, evt_rdy, wq_s, rr_s, rd_s, ev_s;
  logic [3:0]  p_type = 4'h0, p_cnt = 4'h0, cmd_type;
  args_t       p_args = 64'h0, cmd_args;
  byte_t       raw_od, cmd_len;
  logic [87:0] h_sr, d_sr;
  int          bad_count = 0, num_checks = 0;
  int          h_n, d_n, cmd_n, raw_n;

  serial_link_if lnk ();
  host_framer u_host_framer (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .lnk(lnk), .i_address(address), .i_read(read), .i_write(write),
    .i_writedata(writedata), .i_byteenable(4'hF),
    .o_readdata(readdata), .o_waitrequest(waitrequest), .o_irq(irq));
  radio_framer u_radio_framer (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .lnk(lnk), .o_framed(framed), .o_raw_valid(raw_ov),
    .o_raw_data(raw_od), .i_raw_valid(raw_iv), .i_raw_data(p_args[7:0]),
    .o_raw_ready(raw_rdy), .o_cmd_valid(cmd_v), .o_cmd_type(cmd_type),
    .o_cmd_len(cmd_len), .o_cmd_args(cmd_args), .i_rsp_valid(rsp_v),
    .i_rsp_type(p_type), .i_rsp_cnt(p_cnt), .i_rsp_args(p_args),
    .o_rsp_ready(rsp_rdy), .i_evt_valid(evt_v), .i_evt_type(p_type),
    .i_evt_cnt(p_cnt), .i_evt_args(p_args), .o_evt_ready(evt_rdy));
  serial_link_chk u_chk (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_h2d_data(lnk.h2d_data), .i_h2d_valid(lnk.h2d_valid),
    .i_d2h_data(lnk.d2h_data), .i_d2h_valid(lnk.d2h_valid));

  always #5 i_clock = ~i_clock;

  // Settled values mid-cycle equal what the next rising edge samples
  always @(negedge i_clock) begin
    wq_s = waitrequest;
    rdata_s = readdata;
    rr_s = raw_rdy;
    rd_s = rsp_rdy;
    ev_s = evt_rdy;
    if (cmd_v) cmd_n++;
    if (raw_ov) raw_n++;
    if (lnk.h2d_valid) begin
      h_n++;
      h_sr = {h_sr[79:0], lnk.h2d_data};
    end
    if (lnk.d2h_valid) begin
      d_n++;
      d_sr = {d_sr[79:0], lnk.d2h_data};
    end
  end

  task automatic complete_run();
    if (bad_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(string what, logic [87:0] seen, logic [87:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic av(input logic is_wr, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge i_clock);
    address <= a;
    write <= is_wr;
    read <= !is_wr;
    writedata <= d;
    // A slave that never answers is left to the watchdog
    do begin
      @(posedge i_clock);
    end while (wq_s);
    q = rdata_s;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    av(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    av(1'b0, a, 32'h0, q);
  endtask

  // Kind 0 raw byte, 1 reply, 2 event; held until its ready is seen
  task automatic rad(input int k, input logic [3:0] t, input logic [3:0] c,
                     input args_t a);
    @(posedge i_clock);
    p_type <= t;
    p_cnt <= c;
    p_args <= a;
    raw_iv <= (k == 0);
    rsp_v <= (k == 1);
    evt_v <= (k == 2);
    do begin
      @(posedge i_clock);
    end while (!(k == 0 ? rr_s : k == 1 ? rd_s : ev_s));
    raw_iv <= 1'b0;
    rsp_v <= 1'b0;
    evt_v <= 1'b0;
  endtask

  task automatic settle();
    repeat (16) @(posedge i_clock);
  endtask

  task automatic clr();
    h_n = 0;
    d_n = 0;
    cmd_n = 0;
    raw_n = 0;
  endtask

  task automatic send(input logic [31:0] hdr, input logic [63:0] a);
    wr(`REG_TXHDR, hdr);
    wr(`REG_TXARG_LO, a[31:0]);
    wr(`REG_TXARG_HI, a[63:32]);
    clr();
    wr(`REG_CTRL, 32'h1);
    settle();
  endtask

  task automatic t_reset();
    logic [31:0] q;
    rd(`REG_STATUS, q);
    check("status", q, 0);
    wr(8'h40, 32'hFFFFFFFF);
    rd(8'h40, q);
    check("unmapped", q, 0);
    check("framed", framed, 0);
  endtask

  task automatic t_raw();
    logic [31:0] q;
    clr();
    wr(`REG_RAW, 32'h5A);
    settle();
    check("raw in", {raw_n[7:0], raw_od}, 16'h015A);
    rad(0, 4'h0, 4'h0, 64'h3C);
    settle();
    check("irq masked", irq, 0);
    wr(`REG_MASK, 32'h4);
    @(negedge i_clock);
    check("irq", irq, 1);
    rd(`REG_STATUS, q);
    check("raw flag", q[2], 1);
    @(negedge i_clock);
    check("irq cleared", irq, 0);
    rd(`REG_RAW, q);
    check("raw out", q[7:0], 8'h3C);
  endtask

  task automatic t_entry();
    logic [31:0] q;
    send(32'h0600, 64'h4746_4354_4E45);
    check("bad key", {d_n[7:0], framed}, 0);
    send(32'h0600, 64'h4746_4354_4E44);
    check("entry", {h_n[7:0], h_sr[71:0]},
          {8'h09, 72'hFB0700444E54434647});
    check("ack", {d_n[7:0], d_sr[23:0]}, 32'h03FB0110);
    check("framed", framed, 1);
    rd(`REG_STATUS, q);
    check("ack flags", q[4:0] & 5'h11, 5'h11);
    rd(`REG_RXINFO, q);
    check("ack info", q[15:0], 16'h0110);
  endtask

  task automatic t_cmd();
    logic [31:0] q;
    // Byte must leave the host yet never surface as raw data
    clr();
    wr(`REG_RAW, 32'h12);
    settle();
    check("raw framed", {h_n[7:0], raw_n[7:0]}, 16'h0100);
    send(32'h0805, 64'h8877_6655_4433_2211);
    check("cmd wire", h_sr, 88'hFB09051122334455667788);
    check("cmd", {cmd_n[7:0], cmd_type, cmd_len}, 20'h01509);
    check("cmd args", cmd_args, 64'h8877665544332211);
    check("no raw", raw_n, 0);
    clr();
    rad(1, 4'h5, 4'h1, 64'h01);
    settle();
    check("reply", {d_n[7:0], d_sr[31:0]}, 40'h04FB021501);
    rd(`REG_RXINFO, q);
    check("reply info", q[15:0], 16'h0215);
  endtask

  task automatic t_evt();
    logic [31:0] q;
    clr();
    rad(2, 4'h6, 4'h2, 64'hBEEF);
    settle();
    check("event", {d_n[7:0], d_sr[39:0]}, 48'h05FB0326EFBE);
    rd(`REG_STATUS, q);
    check("event flag", q[1], 1);
    rd(`REG_RXARG_LO, q);
    check("event args", q, 32'h0000BEEF);
  endtask

  task automatic t_exit();
    send(32'h0001, 64'h0);
    check("exit", {h_n[7:0], h_sr[23:0]}, 32'h03FB0101);
    check("exit state", {d_n[7:0], framed}, 0);
  endtask

  initial begin
    repeat (2) @(posedge i_clock);
    i_rst_n <= 1'b1;
    t_reset();
    t_raw();
    t_entry();
    t_cmd();
    t_evt();
    t_exit();
    complete_run();
  end

  // Whole run is under a thousand cycles
  initial begin
    #50000;
    bad_count++;
    complete_run();
  end
endmodule // serial_protocol_message_framer_tb_top
